// ### verilog/rsa_cfg.svh
/*
  Offsets, field positions, reset values and command codes of the radio
  status and receive address register bank.
  Assumes inclusion by its bare name wherever these values are needed.
*/
`ifndef RSA_CFG_SVH
`define RSA_CFG_SVH

// Register offsets
`define RSA_OFS_IRQ_AND_FIFO_STATE 5'h07
`define RSA_OFS_TX_LOSS_RETRY_COUNTS 5'h08
`define RSA_OFS_RX_POWER_DETECT 5'h09
`define RSA_OFS_PIPE0_RX_ADDRESS 5'h0a
`define RSA_OFS_PIPE1_RX_ADDRESS 5'h0b
`define RSA_OFS_PIPE2_RX_ADDRESS_LOW 5'h0c
`define RSA_OFS_PIPE3_RX_ADDRESS_LOW 5'h0d

// Status register fields
`define RSA_ST_RESERVED_BIT 7
`define RSA_ST_RX_DATA_READY_BIT 6
`define RSA_ST_TX_DATA_SENT_BIT 5
`define RSA_ST_RETRANSMIT_LIMIT_BIT 4
`define RSA_ST_PIPE_MSB 3
`define RSA_ST_PIPE_LSB 1
`define RSA_ST_TX_FULL_BIT 0
`define RSA_PIPE_EMPTY 3'h7

// Observe register fields
`define RSA_OBS_LOST_MSB 7
`define RSA_OBS_LOST_LSB 4
`define RSA_OBS_RETRY_MSB 3
`define RSA_OBS_RETRY_LSB 0
`define RSA_CNT_MAX 4'hf

// Address reset values
`define RSA_PIPE0_RESET 40'he7e7e7e7e7
`define RSA_PIPE1_RESET 40'hc2c2c2c2c2
`define RSA_PIPE2_RESET 8'hc3
`define RSA_PIPE3_RESET 8'hc4

// Address width setting codes and byte counts
`define RSA_AW_4_BYTES 2'h2
`define RSA_AW_5_BYTES 2'h3
`define RSA_AW_BYTES_3 3'h3
`define RSA_AW_BYTES_4 3'h4
`define RSA_AW_BYTES_5 3'h5
`define RSA_ADDR_BYTES_MAX 3'h5

// Serial command byte layout
`define RSA_CMD_OP_MSB 7
`define RSA_CMD_OP_LSB 5
`define RSA_CMD_OP_READ 3'h0
`define RSA_CMD_OP_WRITE 3'h1
`define RSA_CMD_ADDR_MSB 4
`define RSA_CMD_BIT_LAST 3'h7

`endif

// ### verilog/rsa_pkg.sv
/*
  Types of the radio status and receive address register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rsa_pkg;

  typedef enum logic [1:0] {
    RSA_ST_COMMAND,
    RSA_ST_READ,
    RSA_ST_WRITE,
    RSA_ST_IGNORE
  } rsa_state_t;

endpackage

// ### verilog/rsa_sync.sv
/*
  Two flip-flop synchroniser for a level from another clock domain.
  Assumes a synchronous active high reset on the destination clock.
*/
`timescale 1ns/1ps
module rsa_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // rsa_sync

// ### verilog/rsa_w1c_flag.sv
/*
  Sticky event flag cleared by a written one; a set in the clearing
  cycle wins.
  Assumes set and clear are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
module rsa_w1c_flag (
  input wire logic clk,
  input wire logic rst,
  input wire logic set,
  input wire logic clr,
  output logic flag_r
);

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (set) begin
      flag_r <= 1'b1;
    end else if (clr) begin
      flag_r <= 1'b0;
    end
  end

endmodule // rsa_w1c_flag

// ### verilog/rsa_regs.sv
/*
  Radio status, transmit observe, power detect and receive address
  registers behind a serial slave port (mode 0, MSB first).
  Assumes the radio engine signals are on SYS_CLK; the serial pins are
  asynchronous and SCK runs well below a quarter of SYS_CLK.
*/
// Contract
// [RULE1] During the command byte the status register is shifted out on the output line.
// [RULE2] Receive-data-ready flag in bit 6 sets on a new payload and clears on a written one.
// [RULE3] Data-sent flag in bit 5 sets on transmit done, or on ack when auto ack is on.
// [RULE4] Retransmit-limit flag in bit 4 sets at the retry limit and clears on a written one.
// [RULE5] While the retransmit-limit flag is set radio traffic halts until software clears it.
// [RULE6] Bits 3:1 report the head pipe 000-101, with 111 (reset) meaning receive FIFO empty.
// [RULE7] Bit 0 reads 1 when the transmit FIFO is full and 0 otherwise.
// [RULE8] Lost-packet counter in bits 7:4 counts lost packets and saturates at 15.
// [RULE9] Any write to the channel register resets the lost-packet counter.
// [RULE10] Retry counter in bits 3:0 counts retries and clears when a new packet starts.
// [RULE11] Power-detect bit 0 shows power above threshold and bits 7:1 read zero.
// [RULE12] Pipe 0 address holds up to 5 bytes, LSB first, as many as the width setting says.
// [RULE13] Pipe 1 address holds up to 5 bytes, LSB first, with its own reset value.
// [RULE14] Pipe 2 and 3 store only the low byte and borrow bits 39:8 from pipe 1.
// [RULE15] Pipe 2 low byte resets to 0xc3 and pipe 3 low byte to 0xc4.
// [RULE16] Written zeros leave flags unchanged and writes to read-only fields are ignored.
`timescale 1ns/1ps
`include "rsa_cfg.svh"
module rsa_regs
  import rsa_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SPI_SCK,
  input wire logic SPI_CSN_N,
  input wire logic SPI_MOSI,
  output logic SPI_MISO,
  output logic SPI_MISO_OE,
  input wire logic RX_PAYLOAD_STORED,
  input wire logic TX_PACKET_DONE,
  input wire logic AUTO_ACK_ON,
  input wire logic ACK_RECEIVED,
  input wire logic RETRY_LIMIT_HIT,
  input wire logic [2:0] RX_HEAD_PIPE,
  input wire logic RX_FIFO_EMPTY,
  input wire logic TX_FIFO_FULL,
  input wire logic PACKET_LOST,
  input wire logic RETRANSMIT_DONE,
  input wire logic NEW_PACKET_START,
  input wire logic CHANNEL_WRITE,
  input wire logic POWER_ABOVE_THRESHOLD,
  input wire logic [1:0] ADDRESS_WIDTH_SETTING,
  output logic RADIO_HALT,
  output logic RX_DATA_READY_FLAG,
  output logic TX_DATA_SENT_FLAG,
  output logic RETRANSMIT_LIMIT_FLAG,
  output logic [39:0] PIPE0_RX_ADDRESS,
  output logic [39:0] PIPE1_RX_ADDRESS,
  output logic [39:0] PIPE2_RX_ADDRESS,
  output logic [39:0] PIPE3_RX_ADDRESS
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic sck_s;
  logic csn_n_s;
  logic mosi_s;
  logic sck_d_r;
  logic csn_n_d_r;
  logic sck_rise;
  logic sck_fall;
  logic csn_fall;
  logic csn_rise;

  rsa_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .clk(SYS_CLK),
    .rst(RST),
    .async_in(SPI_SCK),
    .sync_out(sck_s)
  );

  rsa_sync #(.RESET_VAL(1'b1)) u_sync_csn (
    .clk(SYS_CLK),
    .rst(RST),
    .async_in(SPI_CSN_N),
    .sync_out(csn_n_s)
  );

  rsa_sync #(.RESET_VAL(1'b0)) u_sync_mosi (
    .clk(SYS_CLK),
    .rst(RST),
    .async_in(SPI_MOSI),
    .sync_out(mosi_s)
  );

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sck_d_r <= 1'b0;
      csn_n_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      csn_n_d_r <= csn_n_s;
    end
  end

  assign csn_fall = csn_n_d_r & ~csn_n_s;
  assign csn_rise = ~csn_n_d_r & csn_n_s;
  assign sck_rise = ~csn_n_s & ~sck_d_r & sck_s;
  assign sck_fall = ~csn_n_s & sck_d_r & ~sck_s;

  //////////////////////////////////////////////////////////////////////////
  // Status flags and counters

  logic [2:0] flag_clr;
  logic tx_sent_set;
  logic [3:0] lost_cnt_r;
  logic [3:0] retry_cnt_r;
  logic [2:0] pipe_field;
  logic [7:0] status_byte;
  logic [7:0] observe_byte;
  logic [7:0] power_byte;

  assign tx_sent_set = AUTO_ACK_ON ? ACK_RECEIVED : TX_PACKET_DONE; // [RULE3]

  rsa_w1c_flag u_flag_rx_ready (
    .clk(SYS_CLK),
    .rst(RST),
    .set(RX_PAYLOAD_STORED), // [RULE2]
    .clr(flag_clr[2]),
    .flag_r(RX_DATA_READY_FLAG)
  );

  rsa_w1c_flag u_flag_tx_sent (
    .clk(SYS_CLK),
    .rst(RST),
    .set(tx_sent_set),
    .clr(flag_clr[1]),
    .flag_r(TX_DATA_SENT_FLAG)
  );

  rsa_w1c_flag u_flag_retry_limit (
    .clk(SYS_CLK),
    .rst(RST),
    .set(RETRY_LIMIT_HIT), // [RULE4]
    .clr(flag_clr[0]),
    .flag_r(RETRANSMIT_LIMIT_FLAG)
  );

  assign RADIO_HALT = RETRANSMIT_LIMIT_FLAG; // [RULE5]

  always_ff @(posedge SYS_CLK) begin
    if (RST || CHANNEL_WRITE) begin
      lost_cnt_r <= 4'h0; // [RULE9]
    end else if (PACKET_LOST && lost_cnt_r != `RSA_CNT_MAX) begin
      lost_cnt_r <= lost_cnt_r + 4'h1; // [RULE8]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST || NEW_PACKET_START) begin
      retry_cnt_r <= 4'h0; // [RULE10]
    end else if (RETRANSMIT_DONE && retry_cnt_r != `RSA_CNT_MAX) begin
      retry_cnt_r <= retry_cnt_r + 4'h1; // [RULE10]
    end
  end

  assign pipe_field = RX_FIFO_EMPTY ? `RSA_PIPE_EMPTY : RX_HEAD_PIPE; // [RULE6]

  always_comb begin
    status_byte = 8'h00;
    status_byte[`RSA_ST_RX_DATA_READY_BIT] = RX_DATA_READY_FLAG;
    status_byte[`RSA_ST_TX_DATA_SENT_BIT] = TX_DATA_SENT_FLAG;
    status_byte[`RSA_ST_RETRANSMIT_LIMIT_BIT] = RETRANSMIT_LIMIT_FLAG;
    status_byte[`RSA_ST_PIPE_MSB:`RSA_ST_PIPE_LSB] = pipe_field; // [RULE6]
    status_byte[`RSA_ST_TX_FULL_BIT] = TX_FIFO_FULL; // [RULE7]
    observe_byte = 8'h00;
    observe_byte[`RSA_OBS_LOST_MSB:`RSA_OBS_LOST_LSB] = lost_cnt_r; // [RULE8]
    observe_byte[`RSA_OBS_RETRY_MSB:`RSA_OBS_RETRY_LSB] = retry_cnt_r; // [RULE10]
    power_byte = {7'h00, POWER_ABOVE_THRESHOLD}; // [RULE11]
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial command engine

  rsa_state_t state_r;
  logic [2:0] bit_cnt_r;
  logic [6:0] rx_sh_r;
  logic [7:0] tx_sh_r;
  logic [4:0] addr_r;
  logic [2:0] idx_r;
  logic load_r;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic [2:0] aw_bytes;
  logic [39:0] pipe0_r;
  logic [39:0] pipe1_r;
  logic [7:0] pipe2_r;
  logic [7:0] pipe3_r;

  assign byte_done = sck_rise && bit_cnt_r == `RSA_CMD_BIT_LAST;
  assign rx_byte = {rx_sh_r, mosi_s};

  always_comb begin
    unique case (ADDRESS_WIDTH_SETTING)
      `RSA_AW_5_BYTES: aw_bytes = `RSA_AW_BYTES_5;
      `RSA_AW_4_BYTES: aw_bytes = `RSA_AW_BYTES_4;
      default: aw_bytes = `RSA_AW_BYTES_3;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST || csn_fall) begin
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 7'h00;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r <= rx_byte[6:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST || csn_rise || csn_fall) begin
      state_r <= RSA_ST_COMMAND;
      addr_r <= 5'h00;
    end else if (byte_done && state_r == RSA_ST_COMMAND) begin
      addr_r <= rx_byte[`RSA_CMD_ADDR_MSB:0];
      unique case (rx_byte[`RSA_CMD_OP_MSB:`RSA_CMD_OP_LSB])
        `RSA_CMD_OP_READ: state_r <= RSA_ST_READ;
        `RSA_CMD_OP_WRITE: state_r <= RSA_ST_WRITE;
        default: state_r <= RSA_ST_IGNORE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST || csn_fall) begin
      idx_r <= 3'h0;
    end else if (byte_done && state_r != RSA_ST_COMMAND && idx_r != `RSA_ADDR_BYTES_MAX) begin
      idx_r <= idx_r + 3'h1;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (idx_r == 3'h0) begin
      unique case (addr_r)
        `RSA_OFS_IRQ_AND_FIFO_STATE: rd_byte = status_byte;
        `RSA_OFS_TX_LOSS_RETRY_COUNTS: rd_byte = observe_byte;
        `RSA_OFS_RX_POWER_DETECT: rd_byte = power_byte;
        `RSA_OFS_PIPE2_RX_ADDRESS_LOW: rd_byte = pipe2_r;
        `RSA_OFS_PIPE3_RX_ADDRESS_LOW: rd_byte = pipe3_r;
        default: rd_byte = 8'h00;
      endcase
    end
    if (idx_r < `RSA_ADDR_BYTES_MAX) begin
      if (addr_r == `RSA_OFS_PIPE0_RX_ADDRESS) begin
        rd_byte = pipe0_r[idx_r*8 +: 8];
      end else if (addr_r == `RSA_OFS_PIPE1_RX_ADDRESS) begin
        rd_byte = pipe1_r[idx_r*8 +: 8];
      end
    end
  end

  // Next byte loads on the falling edge that follows a completed byte
  always_ff @(posedge SYS_CLK) begin
    if (RST || csn_fall) begin
      load_r <= 1'b0;
    end else if (byte_done) begin
      load_r <= 1'b1;
    end else if (sck_fall) begin
      load_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      tx_sh_r <= 8'h00;
    end else if (csn_fall) begin
      tx_sh_r <= status_byte; // [RULE1]
    end else if (sck_fall) begin
      if (load_r) begin
        tx_sh_r <= (state_r == RSA_ST_READ) ? rd_byte : 8'h00;
      end else begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b0}; // [RULE1]
      end
    end
  end

  assign SPI_MISO = tx_sh_r[7];
  assign SPI_MISO_OE = ~csn_n_s;

  //////////////////////////////////////////////////////////////////////////
  // Register writes

  logic wr_byte;

  assign wr_byte = byte_done && state_r == RSA_ST_WRITE;

  // Only the three flag bits act; read-only fields ignore the write
  assign flag_clr = (wr_byte && idx_r == 3'h0 && addr_r == `RSA_OFS_IRQ_AND_FIFO_STATE) ?
                    rx_byte[`RSA_ST_RX_DATA_READY_BIT:`RSA_ST_RETRANSMIT_LIMIT_BIT] :
                    3'h0; // [RULE16]

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pipe0_r <= `RSA_PIPE0_RESET;
    end else if (wr_byte && addr_r == `RSA_OFS_PIPE0_RX_ADDRESS && idx_r < aw_bytes) begin
      pipe0_r[idx_r*8 +: 8] <= rx_byte; // [RULE12]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pipe1_r <= `RSA_PIPE1_RESET; // [RULE13]
    end else if (wr_byte && addr_r == `RSA_OFS_PIPE1_RX_ADDRESS && idx_r < aw_bytes) begin
      pipe1_r[idx_r*8 +: 8] <= rx_byte; // [RULE13]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pipe2_r <= `RSA_PIPE2_RESET; // [RULE15]
    end else if (wr_byte && addr_r == `RSA_OFS_PIPE2_RX_ADDRESS_LOW && idx_r == 3'h0) begin
      pipe2_r <= rx_byte; // [RULE14]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pipe3_r <= `RSA_PIPE3_RESET; // [RULE15]
    end else if (wr_byte && addr_r == `RSA_OFS_PIPE3_RX_ADDRESS_LOW && idx_r == 3'h0) begin
      pipe3_r <= rx_byte; // [RULE14]
    end
  end

  assign PIPE0_RX_ADDRESS = pipe0_r;
  assign PIPE1_RX_ADDRESS = pipe1_r;
  assign PIPE2_RX_ADDRESS = {pipe1_r[39:8], pipe2_r}; // [RULE14]
  assign PIPE3_RX_ADDRESS = {pipe1_r[39:8], pipe3_r}; // [RULE14]

endmodule // rsa_regs

// ### bench/rsa_regs_chk.sv
/*
  Port checks for the status and receive address register bank.
  Assumes a bind to rsa_regs; one domain on SYS_CLK with RST.
*/
`timescale 1ns/1ps
module rsa_regs_chk (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SPI_CSN_N,
  input wire logic SPI_MISO_OE,
  input wire logic RX_PAYLOAD_STORED,
  input wire logic TX_PACKET_DONE,
  input wire logic AUTO_ACK_ON,
  input wire logic ACK_RECEIVED,
  input wire logic RETRY_LIMIT_HIT,
  input wire logic RADIO_HALT,
  input wire logic RX_DATA_READY_FLAG,
  input wire logic TX_DATA_SENT_FLAG,
  input wire logic RETRANSMIT_LIMIT_FLAG,
  input wire logic [39:0] PIPE0_RX_ADDRESS,
  input wire logic [39:0] PIPE1_RX_ADDRESS,
  input wire logic [39:0] PIPE2_RX_ADDRESS,
  input wire logic [39:0] PIPE3_RX_ADDRESS
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  // Port quiet long enough that no serial write is pending
  sequence s_idle;
    SPI_CSN_N [*6];
  endsequence
  property p_rx_set;
    RX_PAYLOAD_STORED |=> RX_DATA_READY_FLAG;
  endproperty
  property p_sent_set;
    (TX_PACKET_DONE && !AUTO_ACK_ON) || (ACK_RECEIVED && AUTO_ACK_ON) |=> TX_DATA_SENT_FLAG;
  endproperty
  property p_sent_cause;
    $rose(TX_DATA_SENT_FLAG) |->
      ($past(AUTO_ACK_ON) ? $past(ACK_RECEIVED) : $past(TX_PACKET_DONE));
  endproperty
  property p_limit_set;
    RETRY_LIMIT_HIT |=> RETRANSMIT_LIMIT_FLAG;
  endproperty
  property p_halt;
    RADIO_HALT == RETRANSMIT_LIMIT_FLAG;
  endproperty
  property p_flag_hold;
    s_idle |=> ({RX_DATA_READY_FLAG, TX_DATA_SENT_FLAG, RETRANSMIT_LIMIT_FLAG}
      & $past({RX_DATA_READY_FLAG, TX_DATA_SENT_FLAG, RETRANSMIT_LIMIT_FLAG}))
      == $past({RX_DATA_READY_FLAG, TX_DATA_SENT_FLAG, RETRANSMIT_LIMIT_FLAG});
  endproperty
  property p_addr_hold;
    s_idle |=> $stable(PIPE0_RX_ADDRESS) && $stable(PIPE1_RX_ADDRESS)
      && $stable(PIPE2_RX_ADDRESS[7:0]) && $stable(PIPE3_RX_ADDRESS[7:0]);
  endproperty
  property p_upper;
    PIPE2_RX_ADDRESS[39:8] == PIPE1_RX_ADDRESS[39:8]
      && PIPE3_RX_ADDRESS[39:8] == PIPE1_RX_ADDRESS[39:8];
  endproperty
  property p_oe_idle;
    s_idle |-> !SPI_MISO_OE;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("ready flag not set");
  a_sent_set: assert property (p_sent_set) else $error("sent flag not set");
  a_sent_cause: assert property (p_sent_cause) else $error("sent flag no cause");
  a_limit_set: assert property (p_limit_set) else $error("limit flag not set");
  a_halt: assert property (p_halt) else $error("halt differs from flag");
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared idle");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved idle");
  a_upper: assert property (p_upper) else $error("upper bytes differ");
  a_oe_idle: assert property (p_oe_idle) else $error("output enabled idle");
endmodule // rsa_regs_chk

// ### bench/rsa_spi_master.sv
/*
  Serial master model for the controller side, mode 0, MSB first.
  Assumes frames start just after a SYS_CLK edge; half period 80 ns.
*/
`timescale 1ns/1ps
module rsa_spi_master (
  output logic sck,
  output logic csn_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    csn_n = 1'b1;
    mosi = 1'b0;
  end
  ////////////////////////////////////////
  // Clock stands low outside frames
  task automatic open_frame();
    csn_n = 1'b0;
    #80;
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      mosi = d[i];
      #80;
      sck = 1'b1;
      q[i] = miso;
      #80;
      sck = 1'b0;
    end
  endtask
  task automatic close_frame();
    csn_n = 1'b1;
    #80;
  endtask
endmodule // rsa_spi_master

// ### bench/tb_top.sv
/*
  Self-checking bench for rsa_regs through the serial master model.
  Assumes the checker and master model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, rst, auto_ack, rx_empty, tx_full, power, sck, csn_n, mosi, miso, oe;
  logic halt, f_rx, f_tx, f_lim;
  logic [2:0] head_pipe;
  logic [1:0] aw;
  logic [7:0] ev, st;
  logic [39:0] rv, p0, p1, p2, p3;
  int errors = 0;
  int check_count = 0;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  rsa_spi_master m (.sck(sck), .csn_n(csn_n), .mosi(mosi), .miso(miso));
  rsa_regs dut (.SYS_CLK(sys_clk), .RST(rst), .SPI_SCK(sck), .SPI_CSN_N(csn_n),
    .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(oe), .RX_PAYLOAD_STORED(ev[0]),
    .TX_PACKET_DONE(ev[1]), .AUTO_ACK_ON(auto_ack), .ACK_RECEIVED(ev[2]),
    .RETRY_LIMIT_HIT(ev[3]), .RX_HEAD_PIPE(head_pipe), .RX_FIFO_EMPTY(rx_empty),
    .TX_FIFO_FULL(tx_full), .PACKET_LOST(ev[4]), .RETRANSMIT_DONE(ev[5]),
    .NEW_PACKET_START(ev[6]), .CHANNEL_WRITE(ev[7]), .POWER_ABOVE_THRESHOLD(power),
    .ADDRESS_WIDTH_SETTING(aw), .RADIO_HALT(halt), .RX_DATA_READY_FLAG(f_rx),
    .TX_DATA_SENT_FLAG(f_tx), .RETRANSMIT_LIMIT_FLAG(f_lim), .PIPE0_RX_ADDRESS(p0),
    .PIPE1_RX_ADDRESS(p1), .PIPE2_RX_ADDRESS(p2), .PIPE3_RX_ADDRESS(p3));
  ////////////////////////////////////////
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      @(posedge sys_clk) #1 ev[b] = 1'b1;
      @(posedge sys_clk) #1 ev[b] = 1'b0;
    end
    repeat (2) @(posedge sys_clk);
  endtask
  // One frame: command, then n data bytes; status and read data land in st and rv
  task automatic acc(input logic [2:0] op, input logic [4:0] a, input logic [39:0] wv,
                     input int n);
    logic [7:0] q;
    @(posedge sys_clk) #1 m.open_frame();
    chk(oe, 1'b1);
    m.xfer({op, a}, st);
    rv = '0;
    for (int k = 0; k < n; k++) begin
      m.xfer(wv[8*k+:8], q);
      rv[8*k+:8] = q;
    end
    m.close_frame();
    chk(oe, 1'b0);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    acc(3'h0, 5'h07, '0, 1);
    chk(st, 8'h0e);
    acc(3'h0, 5'h0a, '0, 5);
    chk(rv, 40'he7e7e7e7e7);
    acc(3'h0, 5'h0b, '0, 5);
    chk(rv, 40'hc2c2c2c2c2);
    acc(3'h0, 5'h0c, '0, 1);
    chk(rv, 8'hc3);
    acc(3'h0, 5'h0d, '0, 1);
    chk(rv, 8'hc4);
    chk(p3, 40'hc2c2c2c2c4);
    $display("done reset values");
  endtask
  task automatic t_flags();
    pulse(0, 1);
    pulse(1, 1);
    pulse(3, 1);
    acc(3'h1, 5'h07, 40'h8f, 1);
    chk(st, 8'h7e);
    chk(halt, 1'b1);
    acc(3'h0, 5'h07, '0, 0);
    chk(st, 8'h7e);
    acc(3'h1, 5'h07, 40'h40, 1);
    acc(3'h1, 5'h07, 40'h10, 1);
    acc(3'h0, 5'h07, '0, 0);
    chk(st, 8'h2e);
    chk(halt, 1'b0);
    auto_ack = 1'b1;
    acc(3'h1, 5'h07, 40'h20, 1);
    pulse(1, 1);
    chk(f_tx, 1'b0);
    pulse(2, 1);
    chk(f_tx, 1'b1);
    acc(3'h7, 5'h07, 40'h70, 1);
    chk(rv, 8'h00);
    chk(f_tx, 1'b1);
    acc(3'h1, 5'h07, 40'h70, 1);
    chk({f_rx, f_tx, f_lim}, 3'h0);
    $display("done flags");
  endtask
  task automatic t_pipes();
    rx_empty = 1'b0;
    for (int p = 0; p < 6; p++) begin
      head_pipe = 3'(p);
      tx_full = p[0];
      acc(3'h0, 5'h07, '0, 0);
      chk(st, {4'h0, 3'(p), p[0]});
    end
    rx_empty = 1'b1;
    $display("done pipes");
  endtask
  task automatic t_counters();
    pulse(4, 17);
    pulse(5, 3);
    acc(3'h1, 5'h08, 40'h55, 1);
    acc(3'h0, 5'h08, '0, 1);
    chk(rv, 8'hf3);
    pulse(6, 1);
    acc(3'h0, 5'h08, '0, 1);
    chk(rv, 8'hf0);
    pulse(7, 1);
    acc(3'h0, 5'h08, '0, 1);
    chk(rv, 8'h00);
    for (int v = 0; v < 2; v++) begin
      power = v[0];
      acc(3'h1, 5'h09, 40'hfe, 1);
      acc(3'h0, 5'h09, '0, 1);
      chk(rv, {7'h0, v[0]});
    end
    // Reset in mid-run returns the lost-packet counter and the halt flag to zero
    pulse(4, 2);
    pulse(3, 1);
    chk(halt, 1'b1);
    @(posedge sys_clk) #1 rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    acc(3'h0, 5'h08, '0, 1);
    chk(rv, 8'h00);
    chk(halt, 1'b0);
    $display("done counters");
  endtask
  task automatic t_addr();
    acc(3'h1, 5'h0b, 40'h1122334455, 5);
    chk(p1, 40'h1122334455);
    aw = 2'h2;
    acc(3'h1, 5'h0a, 40'haabbccddee, 4);
    aw = 2'h1;
    acc(3'h1, 5'h0a, 40'h0102030405, 3);
    acc(3'h0, 5'h0a, '0, 5);
    chk(rv, 40'he7bb030405);
    chk(p0, 40'he7bb030405);
    acc(3'h1, 5'h0c, 40'h5a, 1);
    acc(3'h1, 5'h0d, 40'ha5, 1);
    chk(p2, 40'h112233445a);
    chk(p3, 40'h11223344a5);
    $display("done addresses");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    {rst, rx_empty, aw} = 4'hf;
    {auto_ack, tx_full, power, head_pipe, ev} = '0;
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_reset();
    t_flags();
    t_pipes();
    t_counters();
    t_addr();
    tally_and_finish();
  end
  initial begin
    #500000;
    errors++;
    tally_and_finish();
  end
endmodule // tb_top
bind rsa_regs rsa_regs_chk u_chk (.SYS_CLK, .RST, .SPI_CSN_N, .SPI_MISO_OE,
  .RX_PAYLOAD_STORED, .TX_PACKET_DONE, .AUTO_ACK_ON, .ACK_RECEIVED, .RETRY_LIMIT_HIT,
  .RADIO_HALT, .RX_DATA_READY_FLAG, .TX_DATA_SENT_FLAG, .RETRANSMIT_LIMIT_FLAG,
  .PIPE0_RX_ADDRESS, .PIPE1_RX_ADDRESS, .PIPE2_RX_ADDRESS, .PIPE3_RX_ADDRESS);
